// ---- include/spci_pkg.sv ----
// constants, command codes and helper functions shared by both ends
// assumes a single-rank synchronous dram pin interface, one clock
package spci_pkg;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int COL_W = 9;
  localparam int FULL_ADDR_W = BANK_W + ADDR_W + COL_W;
  localparam int PRE_FLAG_BIT = 10;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BL_W = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_CL_W = 3;
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0020;
  localparam logic [MODE_BL_W-1:0] BL_FULL_PAGE = 3'h7;
  localparam int PIPE_D = 3;
  localparam int MASK_LAT = 2;

  typedef enum logic [3:0] {
    CMD_DESEL = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACT = 4'h2,
    CMD_READ = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_BST = 4'h5,
    CMD_PRE = 4'h6,
    CMD_REF = 4'h7,
    CMD_MRS = 4'h8
  } spci_cmd_t;

  typedef enum logic [2:0] {
    PS_RUN = 3'h0,
    PS_SUSPEND = 3'h1,
    PS_PD_PRE = 3'h2,
    PS_PD_ACT = 3'h3,
    PS_SELF_REF = 3'h4
  } spci_pwr_t;

  // pins {sel_n, row_n, col_n, wr_n}, all low active
  function automatic logic [3:0] spci_cmd_pins(input spci_cmd_t c);
    case (c)
      CMD_DESEL: spci_cmd_pins = 4'hf;
      CMD_NOP: spci_cmd_pins = 4'h7;
      CMD_ACT: spci_cmd_pins = 4'h3;
      CMD_READ: spci_cmd_pins = 4'h5;
      CMD_WRITE: spci_cmd_pins = 4'h4;
      CMD_BST: spci_cmd_pins = 4'h6;
      CMD_PRE: spci_cmd_pins = 4'h2;
      CMD_REF: spci_cmd_pins = 4'h1;
      CMD_MRS: spci_cmd_pins = 4'h0;
      default: spci_cmd_pins = 4'h7;
    endcase
  endfunction

  function automatic spci_cmd_t spci_cmd_decode(input logic [3:0] p);
    if (p[3]) begin
      spci_cmd_decode = CMD_DESEL;
    end else begin
      case (p[2:0])
        3'h7: spci_cmd_decode = CMD_NOP;
        3'h3: spci_cmd_decode = CMD_ACT;
        3'h5: spci_cmd_decode = CMD_READ;
        3'h4: spci_cmd_decode = CMD_WRITE;
        3'h6: spci_cmd_decode = CMD_BST;
        3'h2: spci_cmd_decode = CMD_PRE;
        3'h1: spci_cmd_decode = CMD_REF;
        3'h0: spci_cmd_decode = CMD_MRS;
        default: spci_cmd_decode = CMD_NOP;
      endcase
    end
  endfunction
endpackage

// ---- include/spci_if.sv ----
// pin bundle between memory controller and dram device
// assumes both ends share clk_i; data wire resolved here from the enables
`timescale 1ns/10ps
interface spci_if;
  import spci_pkg::*;
  logic clk_gate;
  logic sel_n;
  logic row_n;
  logic col_n;
  logic wr_n;
  logic [BANK_W-1:0] bank_sel;
  logic [ADDR_W-1:0] addr;
  logic low_byte_mask;
  logic high_byte_mask;
  logic [DATA_W-1:0] ctrl_dq;
  logic ctrl_dq_oe;
  logic [DATA_W-1:0] mem_dq;
  logic [LANES-1:0] mem_dq_oe;
  logic [DATA_W-1:0] dq;

  // undriven lanes read as zero
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign dq[i*LANE_W +: LANE_W] = mem_dq_oe[i] ? mem_dq[i*LANE_W +: LANE_W] :
                                    ctrl_dq_oe ? ctrl_dq[i*LANE_W +: LANE_W] : 8'h00;
  end

  modport ctrl (
    output clk_gate, sel_n, row_n, col_n, wr_n, bank_sel, addr,
    output low_byte_mask, high_byte_mask, ctrl_dq, ctrl_dq_oe,
    input dq
  );
  modport mem (
    input clk_gate, sel_n, row_n, col_n, wr_n, bank_sel, addr,
    input low_byte_mask, high_byte_mask, dq,
    output mem_dq, mem_dq_oe
  );
endinterface

// ---- rtl/spci_mem.sv ----
// dram device end: command decode, banks, bursts, power states, byte masks
// assumes controller drives spci_if.ctrl and shares clk_i
`timescale 1ns/10ps
module spci_mem #(
  parameter int STORE_AW = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pins
  spci_if.mem pins
);
  import spci_pkg::*;

  if (STORE_AW < 1 || STORE_AW > FULL_ADDR_W) begin : g_bad_store_aw
    $error("spci_mem: STORE_AW out of range");
  end

  function automatic logic [COL_W:0] burst_len(input logic [MODE_BL_W-1:0] code);
    case (code)
      3'h0: burst_len = 10'h001;
      3'h1: burst_len = 10'h002;
      3'h2: burst_len = 10'h004;
      3'h3: burst_len = 10'h008;
      default: burst_len = 10'h200;
    endcase
  endfunction

  // bank bits kept below the row bits so banks never alias each other while STORE_AW is at least 11
  function automatic logic [STORE_AW-1:0] store_index(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] r,
                                                     input logic [COL_W-1:0] c);
    store_index = STORE_AW'({r, b, c});
  endfunction

  logic [STORE_AW-1:0] mem_idx;
  logic [DATA_W-1:0] store [2**STORE_AW];

  spci_pwr_t ps_q, ps_d;
  logic [NBANK-1:0] open_q, open_d;
  logic [NBANK-1:0][ADDR_W-1:0] row_q, row_d;
  logic [ADDR_W-1:0] mode_q, mode_d;
  logic bact_q, bact_d;
  logic bwr_q, bwr_d;
  logic bap_q, bap_d;
  logic bfull_q, bfull_d;
  logic [COL_W:0] bleft_q, bleft_d;
  logic [COL_W-1:0] col_q, col_d;
  logic [BANK_W-1:0] bbank_q, bbank_d;
  logic [PIPE_D-1:0] pv_q, pv_d;
  logic [PIPE_D-1:0][DATA_W-1:0] pd_q, pd_d;
  logic [MASK_LAT-1:0][LANES-1:0] msk_q, msk_d;

  spci_cmd_t cmd;
  logic rx_on;
  logic step;
  logic acc_rd;
  logic acc_wr;
  logic [COL_W-1:0] acc_col;
  logic [COL_W-1:0] wrap_mask;
  logic [BANK_W-1:0] acc_bank;
  logic [COL_W:0] blen;
  logic [LANES-1:0] lane_mask;
  logic [MODE_CL_W-1:0] cl;
  logic [1:0] out_sel;
  logic rd_pend;

  assign lane_mask = {pins.high_byte_mask, pins.low_byte_mask};
  assign rx_on = (ps_q == PS_RUN) || (ps_q == PS_SUSPEND);
  assign step = rx_on && pins.clk_gate;
  assign blen = burst_len(mode_q[MODE_BL_LSB +: MODE_BL_W]);
  assign cl = mode_q[MODE_CL_LSB +: MODE_CL_W];
  assign out_sel = (cl >= 3'h3) ? 2'h2 : 2'h1;
  assign mem_idx = store_index(acc_bank, row_q[acc_bank], acc_col);
  // read word in the first two output pipeline stages counts as an access in progress
  assign rd_pend = |pv_q[PIPE_D-2:0];

  always_comb begin
    cmd = rx_on ? spci_cmd_decode({pins.sel_n, pins.row_n, pins.col_n, pins.wr_n}) : CMD_NOP;
    ps_d = ps_q;
    open_d = open_q;
    row_d = row_q;
    mode_d = mode_q;
    bact_d = bact_q;
    bwr_d = bwr_q;
    bap_d = bap_q;
    bfull_d = bfull_q;
    bleft_d = bleft_q;
    col_d = col_q;
    bbank_d = bbank_q;
    pv_d = pv_q;
    pd_d = pd_q;
    msk_d = msk_q;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_col = col_q;
    acc_bank = bbank_q;
    wrap_mask = blen[COL_W-1:0] - 9'h001;
    case (ps_q)
      PS_RUN, PS_SUSPEND: begin
        if (!pins.clk_gate) begin
          if (bact_q || rd_pend) begin
            ps_d = PS_SUSPEND;
          end else if (|open_q) begin
            ps_d = PS_PD_ACT;
          end else if (cmd == CMD_REF) begin
            ps_d = PS_SELF_REF;
          end else begin
            ps_d = PS_PD_PRE;
          end
        end else begin
          ps_d = PS_RUN;
        end
      end
      PS_PD_PRE, PS_PD_ACT, PS_SELF_REF: begin
        if (pins.clk_gate) begin
          ps_d = PS_RUN;
        end
      end
      default: ps_d = PS_RUN;
    endcase
    if (step) begin
      msk_d = {msk_q[0], lane_mask};
      if (bact_q) begin
        acc_rd = !bwr_q;
        acc_wr = bwr_q;
      end
      case (cmd)
        CMD_ACT: begin
          open_d[pins.bank_sel] = 1'b1;
          row_d[pins.bank_sel] = pins.addr;
        end
        CMD_READ, CMD_WRITE: begin
          if (open_q[pins.bank_sel]) begin
            acc_bank = pins.bank_sel;
            acc_col = pins.addr[COL_W-1:0];
            acc_rd = (cmd == CMD_READ);
            acc_wr = (cmd == CMD_WRITE);
            bwr_d = (cmd == CMD_WRITE);
            bap_d = pins.addr[PRE_FLAG_BIT];
            bfull_d = (mode_q[MODE_BL_LSB +: MODE_BL_W] == BL_FULL_PAGE);
            bbank_d = pins.bank_sel;
          end
        end
        CMD_BST: begin
          bact_d = 1'b0;
          acc_rd = 1'b0;
          acc_wr = 1'b0;
        end
        CMD_PRE: begin
          if (pins.addr[PRE_FLAG_BIT]) begin
            open_d = '0;
          end else begin
            open_d[pins.bank_sel] = 1'b0;
          end
          if (pins.addr[PRE_FLAG_BIT] || pins.bank_sel == bbank_q) begin
            bact_d = 1'b0;
            acc_rd = 1'b0;
            acc_wr = 1'b0;
          end
        end
        CMD_MRS: mode_d = pins.addr;
        default: ;
      endcase
      if ((cmd == CMD_READ || cmd == CMD_WRITE) && open_q[pins.bank_sel]) begin
        bleft_d = blen - 10'h001;
        bact_d = (blen != 10'h001) || bfull_d;
        col_d = (acc_col & ~wrap_mask) | ((acc_col + 9'h001) & wrap_mask);
        if (blen == 10'h001 && pins.addr[PRE_FLAG_BIT]) begin
          open_d[pins.bank_sel] = 1'b0;
        end
      end else if (bact_q && (acc_rd || acc_wr)) begin
        col_d = (col_q & ~wrap_mask) | ((col_q + 9'h001) & wrap_mask);
        if (!bfull_q) begin
          bleft_d = bleft_q - 10'h001;
          if (bleft_q == 10'h001) begin
            bact_d = 1'b0;
            if (bap_q) begin
              open_d[bbank_q] = 1'b0;
            end
          end
        end
      end
      pv_d = {pv_q[PIPE_D-2:0], acc_rd};
      pd_d = {pd_q[PIPE_D-2:0], acc_rd ? store[store_index(acc_bank, row_q[acc_bank], acc_col)] : {DATA_W{1'b0}}};
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ps_q <= PS_RUN;
      open_q <= '0;
      row_q <= '0;
      mode_q <= MODE_RST;
      bact_q <= 1'b0;
      bwr_q <= 1'b0;
      bap_q <= 1'b0;
      bfull_q <= 1'b0;
      bleft_q <= '0;
      col_q <= '0;
      bbank_q <= '0;
      pv_q <= '0;
      pd_q <= '0;
      msk_q <= '0;
    end else begin
      ps_q <= ps_d;
      open_q <= open_d;
      row_q <= row_d;
      mode_q <= mode_d;
      bact_q <= bact_d;
      bwr_q <= bwr_d;
      bap_q <= bap_d;
      bfull_q <= bfull_d;
      bleft_q <= bleft_d;
      col_q <= col_d;
      bbank_q <= bbank_d;
      pv_q <= pv_d;
      pd_q <= pd_d;
      msk_q <= msk_d;
    end
  end

  // array write, per lane: every unmasked lane is written on the same edge
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < LANES; i++) begin
      if (!sys_rst_i && step && acc_wr && !lane_mask[i]) begin
        store[mem_idx][i*LANE_W +: LANE_W] <= pins.dq[i*LANE_W +: LANE_W];
      end
    end
  end

  for (genvar i = 0; i < LANES; i++) begin : g_oe
    assign pins.mem_dq_oe[i] = pv_q[out_sel] && !msk_q[MASK_LAT-1][i];
  end

  assign pins.mem_dq = pd_q[out_sel];
endmodule // spci_mem

// ---- rtl/spci_ctrl.sv ----
// controller end: registers user commands onto the pins, captures read data
// assumes user issues legal command order and timing; one clock
`timescale 1ns/10ps
module spci_ctrl #(
  parameter int CAS_LAT = 2,
  parameter int BURST_LEN = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // command request
  input wire logic cmd_valid_i,
  input wire spci_pkg::spci_cmd_t cmd_i,
  input wire logic [spci_pkg::BANK_W-1:0] bank_i,
  input wire logic [spci_pkg::ADDR_W-1:0] addr_i,
  input wire logic clk_gate_i,
  // write data and lane masks
  input wire logic wr_data_en_i,
  input wire logic [spci_pkg::DATA_W-1:0] wr_data_i,
  input wire logic low_lane_mask_i,
  input wire logic high_lane_mask_i,
  // read data
  output logic rd_valid_o,
  output logic [spci_pkg::DATA_W-1:0] rd_data_o,
  // pins
  spci_if.ctrl pins
);
  import spci_pkg::*;

  if (CAS_LAT < 2 || CAS_LAT > 3 ||
      !(BURST_LEN == 1 || BURST_LEN == 2 || BURST_LEN == 4 || BURST_LEN == 8)) begin : g_bad_cfg
    $error("spci_ctrl: unsupported CAS_LAT or BURST_LEN");
  end

  localparam logic [3:0] WAIT_LOAD = 4'(CAS_LAT + 1);
  localparam logic [3:0] CNT_LOAD = 4'(BURST_LEN);

  logic [3:0] cmd_pins_q, cmd_pins_d;
  logic gate_q, gate_d;
  logic [BANK_W-1:0] ba_q, ba_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [LANES-1:0] msk_q, msk_d;
  logic [DATA_W-1:0] dq_q, dq_d;
  logic oe_q, oe_d;
  logic [3:0] wait_q, wait_d;
  logic [3:0] cnt_q, cnt_d;
  logic rv_q, rv_d;
  logic [DATA_W-1:0] rd_q, rd_d;

  always_comb begin
    cmd_pins_d = spci_cmd_pins(cmd_valid_i ? cmd_i : CMD_NOP);
    gate_d = clk_gate_i;
    ba_d = bank_i;
    addr_d = addr_i;
    msk_d = {high_lane_mask_i, low_lane_mask_i};
    dq_d = wr_data_i;
    oe_d = wr_data_en_i;
    wait_d = wait_q;
    cnt_d = cnt_q;
    rv_d = 1'b0;
    rd_d = rd_q;
    if (gate_q) begin
      if (wait_q > 4'h1) begin
        wait_d = wait_q - 4'h1;
      end else if (wait_q == 4'h1 && cnt_q != 4'h0) begin
        rv_d = 1'b1;
        rd_d = pins.dq;
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          wait_d = 4'h0;
        end
      end
    end
    if (cmd_valid_i && cmd_i == CMD_READ) begin
      wait_d = WAIT_LOAD;
      cnt_d = CNT_LOAD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_pins_q <= 4'hf;
      gate_q <= 1'b1;
      ba_q <= '0;
      addr_q <= '0;
      msk_q <= '0;
      dq_q <= '0;
      oe_q <= 1'b0;
      wait_q <= '0;
      cnt_q <= '0;
      rv_q <= 1'b0;
      rd_q <= '0;
    end else begin
      cmd_pins_q <= cmd_pins_d;
      gate_q <= gate_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
      msk_q <= msk_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      wait_q <= wait_d;
      cnt_q <= cnt_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
    end
  end

  assign pins.sel_n = cmd_pins_q[3];
  assign pins.row_n = cmd_pins_q[2];
  assign pins.col_n = cmd_pins_q[1];
  assign pins.wr_n = cmd_pins_q[0];
  assign pins.clk_gate = gate_q;
  assign pins.bank_sel = ba_q;
  assign pins.addr = addr_q;
  assign pins.low_byte_mask = msk_q[0];
  assign pins.high_byte_mask = msk_q[1];
  assign pins.ctrl_dq = dq_q;
  assign pins.ctrl_dq_oe = oe_q;
  assign rd_valid_o = rv_q;
  assign rd_data_o = rd_q;
endmodule // spci_ctrl

// ---- sim/spci_assertions.sv ----
// checker for the controller-to-memory pin bundle
// assumes one shared clock, memory mode cl2 bl1
`timescale 1ns/10ps
module spci_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pin bundle
  input wire logic clk_gate,
  input wire logic sel_n,
  input wire logic row_n,
  input wire logic col_n,
  input wire logic wr_n,
  input wire logic [1:0] bank_sel,
  input wire logic [12:0] addr,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic ctrl_dq_oe,
  input wire logic [15:0] mem_dq,
  input wire logic [1:0] mem_dq_oe,
  input wire logic [15:0] dq
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [3:0] open_q;
  logic [3:0] open_d;
  logic gate_q;
  logic [3:0] cmd;
  logic live;
  assign cmd = {sel_n, row_n, col_n, wr_n};
  assign live = clk_gate && gate_q;
  // open banks as seen on the pins
  always_comb begin
    open_d = open_q;
    if (live && cmd == 4'h3) open_d[bank_sel] = 1'b1;
    if (live && cmd == 4'h2) open_d = addr[10] ? 4'h0 : (open_q & ~(4'h1 << bank_sel));
    if (live && (cmd == 4'h5 || cmd == 4'h4) && addr[10]) open_d[bank_sel] = 1'b0;
  end
  always_ff @(posedge clk_i) begin
    open_q <= sys_rst_i ? 4'h0 : open_d;
    gate_q <= sys_rst_i ? 1'b1 : clk_gate;
  end
  sequence s_read_open;
    live && cmd == 4'h5 && open_q[bank_sel] && !low_byte_mask;
  endsequence
  sequence s_clocked2;
    clk_gate ##1 clk_gate;
  endsequence
  a_reset_idle_pins: assert property (disable iff (1'b0) sys_rst_i |=> sel_n && clk_gate && !ctrl_dq_oe)
    else $error("pins not idle after reset");
  a_read_drive_cl: assert property (s_read_open ##1 s_clocked2 |-> mem_dq_oe[0])
    else $error("read word not driven");
  a_low_mask_float: assert property (low_byte_mask && live ##1 s_clocked2 |-> !mem_dq_oe[0])
    else $error("low lane driven under mask");
  a_high_mask_float: assert property (high_byte_mask && live ##1 s_clocked2 |-> !mem_dq_oe[1])
    else $error("high lane driven under mask");
  a_gate_freeze: assert property (!clk_gate |=> $stable(mem_dq_oe) && $stable(mem_dq))
    else $error("outputs moved on gated edge");
  a_desel_quiet: assert property ((sel_n && clk_gate)[*4] |-> mem_dq_oe == 2'h0)
    else $error("data driven after long deselect");
  a_low_lane_route: assert property (mem_dq_oe[0] |-> dq[7:0] == mem_dq[7:0])
    else $error("low lane not routed");
  a_high_lane_route: assert property (mem_dq_oe[1] |-> dq[15:8] == mem_dq[15:8])
    else $error("high lane not routed");
endmodule // spci_assertions

// ---- sim/tb.sv ----
// bench: controller and memory ends joined by the pin bundle
// assumes 20 MHz clock, inputs driven on falling edges
`timescale 1ns/10ps
module tb;
  import spci_pkg::*;
  localparam int CL = 2;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  spci_cmd_t cmd_i = CMD_NOP;
  logic [BANK_W-1:0] bank_i = 2'h0;
  logic [ADDR_W-1:0] addr_i = 13'h0;
  logic clk_gate_i = 1'b1;
  logic wr_data_en_i = 1'b0;
  logic [DATA_W-1:0] wr_data_i = 16'h0;
  logic low_lane_mask_i = 1'b0;
  logic high_lane_mask_i = 1'b0;
  logic rd_valid_o;
  logic [DATA_W-1:0] rd_data_o;
  logic [5:0] pin_idle;
  int failures = 0;
  int samples_checked = 0;
  logic [1:0] wb [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  logic [12:0] wa [6] = '{13'h3, 13'h4, 13'h4, 13'h5, 13'h5, 13'h9};
  logic [15:0] wd [6] = '{16'h1234, 16'h5678, 16'h9a9a, 16'h1111, 16'h2222, 16'habcd};
  logic [1:0] wm [6] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0};
  logic [1:0] rb [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  logic [12:0] ra [8] = '{13'h3, 13'h4, 13'h5, 13'h3, 13'h3, 13'h3, 13'h3, 13'h9};
  logic [1:0] rm [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h2, 2'h0, 2'h0};
  logic rs [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  int rg [8] = '{0, 0, 0, 0, 0, 0, 2, 0};
  logic [15:0] re [8] = '{16'h1234, 16'h9a78, 16'h1122, 16'h1200, 16'h0000, 16'h0034, 16'h1234, 16'habcd};
  spci_if pins_if ();
  spci_ctrl #(.CAS_LAT(CL), .BURST_LEN(1)) u_spci_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .bank_i(bank_i), .addr_i(addr_i), .clk_gate_i(clk_gate_i),
    .wr_data_en_i(wr_data_en_i), .wr_data_i(wr_data_i), .low_lane_mask_i(low_lane_mask_i),
    .high_lane_mask_i(high_lane_mask_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .pins(pins_if.ctrl));
  spci_mem u_spci_mem (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pins(pins_if.mem));
  spci_assertions u_spci_assertions (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_gate(pins_if.clk_gate),
    .sel_n(pins_if.sel_n), .row_n(pins_if.row_n), .col_n(pins_if.col_n), .wr_n(pins_if.wr_n),
    .bank_sel(pins_if.bank_sel), .addr(pins_if.addr), .low_byte_mask(pins_if.low_byte_mask),
    .high_byte_mask(pins_if.high_byte_mask), .ctrl_dq_oe(pins_if.ctrl_dq_oe), .mem_dq(pins_if.mem_dq),
    .mem_dq_oe(pins_if.mem_dq_oe), .dq(pins_if.dq));
  assign pin_idle = {pins_if.sel_n, pins_if.row_n, pins_if.col_n, pins_if.wr_n, pins_if.clk_gate, pins_if.ctrl_dq_oe};
  always #25 clk_i = ~clk_i;

  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic issue(input spci_cmd_t c, input logic [1:0] b, input logic [12:0] a,
                       input logic [15:0] d = 16'h0, input logic [1:0] m = 2'h0);
    cmd_valid_i = 1'b1;
    cmd_i = c;
    bank_i = b;
    addr_i = a;
    wr_data_i = d;
    wr_data_en_i = (c == CMD_WRITE);
    {high_lane_mask_i, low_lane_mask_i} = m;
    @(negedge clk_i);
  endtask
  task automatic idle(input int n);
    cmd_valid_i = 1'b0;
    wr_data_en_i = 1'b0;
    {high_lane_mask_i, low_lane_mask_i} = 2'h0;
    repeat (n) @(negedge clk_i);
  endtask
  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    check("idle pins", 16'h003e, {10'h0, pin_idle});
  endtask
  // read with optional mask, deselect tail and gated cycles
  task automatic rd_chk(input logic [1:0] b, input logic [12:0] a, input logic [1:0] m, input logic ds,
                        input int g, input logic [15:0] exp);
    int k;
    k = 0;
    issue(CMD_READ, b, a, 16'h0, m);
    cmd_valid_i = ds;
    cmd_i = ds ? CMD_DESEL : CMD_NOP;
    {high_lane_mask_i, low_lane_mask_i} = 2'h0;
    clk_gate_i = (g == 0);
    while (rd_valid_o !== 1'b1 && k < 12) begin
      @(negedge clk_i);
      k++;
      if (k == g) clk_gate_i = 1'b1;
    end
    check("read latency", 16'(CL + 1 + g), 16'(k));
    check("read data", exp, rd_data_o);
    repeat (2) @(negedge clk_i);
    idle(1);
  endtask

  initial begin
    repeat (700) @(posedge clk_i);
    failures++;
    $display("unexpected watchdog expected done seen timeout");
    end_of_test();
  end

  initial begin
    do_reset();
    issue(CMD_MRS, 2'h0, 13'h0020);
    issue(CMD_ACT, 2'h0, 13'h0005);
    issue(CMD_ACT, 2'h2, 13'h0005);
    idle(2);
    for (int i = 0; i < 6; i++) issue(CMD_WRITE, wb[i], wa[i], wd[i], wm[i]);
    idle(2);
    for (int i = 0; i < 8; i++) rd_chk(rb[i], ra[i], rm[i], rs[i], rg[i], re[i]);
    issue(CMD_PRE, 2'h0, 13'h0000);
    idle(2);
    rd_chk(2'h0, 13'h0003, 2'h0, 1'b0, 0, 16'h0000);
    rd_chk(2'h2, 13'h0409, 2'h0, 1'b0, 0, 16'habcd);
    rd_chk(2'h2, 13'h0009, 2'h0, 1'b0, 0, 16'h0000);
    issue(CMD_ACT, 2'h0, 13'h0005);
    issue(CMD_ACT, 2'h2, 13'h0005);
    idle(1);
    issue(CMD_PRE, 2'h1, 13'h0400);
    idle(2);
    rd_chk(2'h2, 13'h0009, 2'h0, 1'b0, 0, 16'h0000);
    // precharge power-down, then self refresh
    clk_gate_i = 1'b0;
    idle(4);
    clk_gate_i = 1'b1;
    idle(3);
    clk_gate_i = 1'b0;
    issue(CMD_REF, 2'h0, 13'h0000);
    idle(4);
    clk_gate_i = 1'b1;
    idle(3);
    issue(CMD_ACT, 2'h0, 13'h0005);
    idle(2);
    // active power-down with a row open
    clk_gate_i = 1'b0;
    idle(3);
    clk_gate_i = 1'b1;
    idle(3);
    rd_chk(2'h0, 13'h0003, 2'h0, 1'b0, 0, 16'h1234);
    do_reset();
    rd_chk(2'h0, 13'h0003, 2'h0, 1'b0, 0, 16'h0000);
    end_of_test();
  end
endmodule // tb
